/* File: common/adc_readout_pkg.sv */
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants and carriers for the serial result readout block.
// ----------------------------------------------------------------------------
package adc_readout_pkg;

	// Widths of the conversion result and the appended status byte.
	localparam int RESULT_BITS = 24;
	localparam int STATUS_BITS = 8;
	localparam int FRAME_BITS  = RESULT_BITS + STATUS_BITS;

	// Frame lengths in serial clocks, without and with the status byte.
	localparam logic [5:0] FRAME_LEN_PLAIN  = 6'd24;
	localparam logic [5:0] FRAME_LEN_STATUS = 6'd32;

	// Command recognised while continuous read is active.
	localparam logic [7:0] READ_DATA_CMD   = 8'h42;
	// Consecutive ones on the data input that form a software reset.
	localparam logic [6:0] SOFT_RESET_ONES = 7'd64;

	// Release timing of the serial output in three-wire mode.
	localparam int CLK_PERIOD_NS = 50;
	localparam int REL_SHORT_NS  = 10;
	localparam int REL_LONG_NS   = 100;
	localparam logic [1:0] REL_SHORT_CYC =
		2'((REL_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0] REL_LONG_CYC =
		2'((REL_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Lead of the abandon warning before a conversion, in master clocks.
	localparam int ABANDON_LEAD_CLKS = 4;

	// Readout options; all reset to zero.
	localparam logic [2:0] CFG_RESET = 3'h0;
	typedef struct packed {
		logic serial_out_release_delay_sel;
		logic continuous_result_read_en;
		logic status_append_en;
	} cfg_t;

	// One conversion result with its status byte.
	typedef struct packed {
		logic [RESULT_BITS-1:0] data;
		logic [STATUS_BITS-1:0] status;
	} conv_t;

endpackage
`default_nettype wire

/* File: core/adc_serial_readout_control.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Three-wire output release delay 10 or 100 ns.
// - Serial clocks ignored while data ready high.
// - Abandon read four clocks before next conversion.
// - Exit on 64 ones or command 0x42.
// - Exit command needs no CRC byte.
// - No continuous read while FIFO enabled.
// - Status byte follows 24-bit result.
// - Three-wire interface resets on last rising edge.
// - Four-wire resets on select rise, output off.
module adc_serial_readout_control (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Serial pins, mode 3, sampled as synchronous inputs.
	input  wire logic                   sclk,
	input  wire logic                   cs_n,
	input  wire logic                   sdi,
	output logic                        sdo,
	output logic                        sdo_oe,
	// Data ready frame, low while a fresh result waits.
	output logic                        rdy_n,
	// Readout options.
	input  wire logic                   cfg_wr,
	input  wire adc_readout_pkg::cfg_t  cfg_wdata,
	output var adc_readout_pkg::cfg_t   cfg_rdata,
	// Related device settings.
	input  wire logic                   select_pin_function_en,
	input  wire logic                   fifo_en,
	// Converter core.
	input  wire logic                   conv_valid,
	input  wire adc_readout_pkg::conv_t conv,
	input  wire logic                   conv_imminent,
	// Event pulses.
	output logic                        read_abandoned,
	output logic                        cont_exit,
	output logic                        soft_reset
);
	import adc_readout_pkg::*;

	cfg_t       cfg, next_cfg;
	logic       sclk_q, cs_q;
	logic       next_rdy_n, drive, next_drive;
	logic [5:0] bit_cnt, next_bit_cnt;
	logic [1:0] rel_cnt, next_rel_cnt;
	logic [7:0] cmd_sr, next_cmd_sr;
	logic [2:0] cmd_cnt, next_cmd_cnt;
	logic [6:0] ones_cnt, next_ones_cnt;
	logic       next_abandon, next_exit, next_soft;

	logic       cont_act, sclk_rise, sclk_fall, cs_rise, load, frame_rise;
	logic       last_bit, last3, shift, abandon, cmd_hit, soft_hit;
	logic [5:0] frame_len;
	logic [7:0] cmd_byte;

	// ------------------------------------------------------------------------
	// Edge detection and frame decode
	// ------------------------------------------------------------------------

	// A FIFO in use disables continuous read whatever the option says.
	assign cont_act   = cfg.continuous_result_read_en & ~fifo_en;
	assign sclk_rise  = sclk & ~sclk_q;
	assign sclk_fall  = ~sclk & sclk_q;
	assign cs_rise    = cs_n & ~cs_q & select_pin_function_en;
	assign load       = conv_valid & cont_act;
	// Clocks count only inside the ready frame, so a result reads once.
	assign frame_rise = sclk_rise & ~cs_n & ~rdy_n & cont_act;
	assign frame_len  = cfg.status_append_en ? FRAME_LEN_STATUS
		: FRAME_LEN_PLAIN;
	assign last_bit   = bit_cnt == frame_len - 6'd1;
	assign last3      = frame_rise & last_bit & ~select_pin_function_en;
	// The first bit is already out at the frame start, so the first
	// falling edge must not shift it away.
	assign shift      = sclk_fall & ~cs_n & ~rdy_n & cont_act
		& (bit_cnt != 6'd0);
	assign abandon    = conv_imminent & ~rdy_n & (bit_cnt != 6'd0)
		& cont_act;
	assign cmd_byte   = {cmd_sr[6:0], sdi};
	// The exit command acts on its eighth bit; no CRC byte is awaited.
	assign cmd_hit    = sclk_rise & ~cs_n & (cmd_cnt == 3'd7)
		& (cmd_byte == READ_DATA_CMD) & cont_act;
	assign soft_hit   = sclk_rise & ~cs_n & sdi
		& (ones_cnt == SOFT_RESET_ONES - 7'd1);

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------

	// Later assignments take priority: soft reset over all else.
	always_comb begin
		next_cfg      = cfg;
		next_rdy_n    = rdy_n;
		next_bit_cnt  = bit_cnt;
		next_drive    = drive;
		next_rel_cnt  = rel_cnt;
		next_cmd_sr   = cmd_sr;
		next_cmd_cnt  = cmd_cnt;
		next_ones_cnt = ones_cnt;
		next_abandon  = 1'b0;
		next_exit     = 1'b0;
		next_soft     = 1'b0;
		// Release countdown after the last bit in three-wire mode.
		if (rel_cnt != 2'd0) begin
			next_rel_cnt = rel_cnt - 2'd1;
			if (rel_cnt == 2'd1) begin
				next_drive = 1'b0;
			end
		end
		if (frame_rise) begin
			if (last_bit) begin
				next_rdy_n   = 1'b1;
				next_bit_cnt = 6'd0;
				if (!select_pin_function_en) begin
					next_rel_cnt = cfg.serial_out_release_delay_sel
						? REL_LONG_CYC : REL_SHORT_CYC;
				end
			end else begin
				next_bit_cnt = bit_cnt + 6'd1;
			end
		end
		if (abandon) begin
			next_rdy_n   = 1'b1;
			next_bit_cnt = 6'd0;
			next_drive   = 1'b0;
			next_rel_cnt = 2'd0;
			next_abandon = 1'b1;
		end
		if (load) begin
			next_rdy_n   = 1'b0;
			next_bit_cnt = 6'd0;
			next_drive   = 1'b1;
			next_rel_cnt = 2'd0;
		end
		// Command and reset detection watches every selected clock.
		if (sclk_rise && !cs_n) begin
			next_cmd_sr   = cmd_byte;
			next_cmd_cnt  = cmd_cnt + 3'd1;
			next_ones_cnt = sdi ? ones_cnt + 7'd1 : 7'd0;
		end
		// A half-read result is spent once the interface resets.
		if (cs_rise) begin
			next_bit_cnt = 6'd0;
			next_drive   = 1'b0;
			next_cmd_cnt = 3'd0;
			if (bit_cnt != 6'd0) begin
				next_rdy_n = 1'b1;
			end
		end
		if (cmd_hit) begin
			next_cfg.continuous_result_read_en = 1'b0;
			next_exit = 1'b1;
		end
		// A software write in the same cycle wins over the exit clear.
		if (cfg_wr) begin
			next_cfg = cfg_wdata;
		end
		if (!cont_act || cmd_hit) begin
			next_rdy_n   = 1'b1;
			next_bit_cnt = 6'd0;
			next_drive   = 1'b0;
			next_rel_cnt = 2'd0;
		end
		if (soft_hit) begin
			next_cfg      = CFG_RESET;
			next_rdy_n    = 1'b1;
			next_bit_cnt  = 6'd0;
			next_drive    = 1'b0;
			next_rel_cnt  = 2'd0;
			next_cmd_cnt  = 3'd0;
			next_ones_cnt = 7'd0;
			next_soft     = 1'b1;
		end
	end

	// Register all control state.
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg            <= CFG_RESET;
			sclk_q         <= 1'b1;
			cs_q           <= 1'b1;
			rdy_n          <= 1'b1;
			bit_cnt        <= 6'd0;
			drive          <= 1'b0;
			rel_cnt        <= 2'd0;
			cmd_sr         <= 8'h00;
			cmd_cnt        <= 3'd0;
			ones_cnt       <= 7'd0;
			read_abandoned <= 1'b0;
			cont_exit      <= 1'b0;
			soft_reset     <= 1'b0;
		end else begin
			cfg            <= next_cfg;
			sclk_q         <= sclk;
			cs_q           <= cs_n;
			rdy_n          <= next_rdy_n;
			bit_cnt        <= next_bit_cnt;
			drive          <= next_drive;
			rel_cnt        <= next_rel_cnt;
			cmd_sr         <= next_cmd_sr;
			cmd_cnt        <= next_cmd_cnt;
			ones_cnt       <= next_ones_cnt;
			read_abandoned <= next_abandon;
			cont_exit      <= next_exit;
			soft_reset     <= next_soft;
		end
	end

	// ------------------------------------------------------------------------
	// Serial output
	// ------------------------------------------------------------------------

	// The status byte is always loaded; a 24-clock frame never reaches it.
	serial_out_shifter #(
		.WIDTH(FRAME_BITS)
	) u_shifter (
		.clk      (clk),
		.rst      (rst),
		.load     (load),
		.load_data({conv.data, conv.status}),
		.shift    (shift),
		.msb      (sdo)
	);

	// A high select pin always floats the output.
	assign sdo_oe    = ~cs_n & drive;
	assign cfg_rdata = cfg;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_REL_SHORT: assert property (
		last3 && !cfg.serial_out_release_delay_sel ##1 !load && cont_act
		|-> drive ##1 !drive)
		else $error("Short output release delay wrong.");
	AST_REL_LONG: assert property (
		last3 && cfg.serial_out_release_delay_sel
		##1 (!load && cont_act)[*2] |-> drive ##1 !drive)
		else $error("Long output release delay wrong.");
	AST_IGNORE_HIGH: assert property (
		rdy_n && sclk_rise && !conv_valid |=> bit_cnt == 6'd0)
		else $error("Clock counted while ready high.");
	AST_ABANDON: assert property (
		abandon |=> rdy_n && read_abandoned && !drive)
		else $error("Read not abandoned.");
	AST_CMD_EXIT: assert property (
		cmd_hit && !cfg_wr && !soft_hit
		|=> !cfg.continuous_result_read_en && cont_exit ##1 !cont_exit)
		else $error("Exit command not honoured.");
	AST_SOFT_RESET: assert property (
		soft_hit |=> cfg == CFG_RESET && rdy_n && soft_reset)
		else $error("Software reset not honoured.");
	AST_FIFO_BLOCK: assert property (
		fifo_en |=> rdy_n)
		else $error("Continuous read active with FIFO.");
	AST_FIRST_BIT: assert property (
		load |=> sdo == $past(conv.data[RESULT_BITS-1]))
		else $error("Result msb not first.");
	AST_FRAME_END: assert property (
		frame_rise && last_bit && !load |=> rdy_n && bit_cnt == 6'd0)
		else $error("Ready not high after full read.");
	AST_CS_FLOAT: assert property (
		cs_n |-> !sdo_oe)
		else $error("Output driven with select high.");
	AST_CS_RESET: assert property (
		cs_rise && !load |=> bit_cnt == 6'd0 && !drive)
		else $error("Select rise did not reset interface.");

	COV_FULL_READ:  cover property (frame_rise && last_bit);
	COV_ABANDON:    cover property (abandon);
	COV_CMD_EXIT:   cover property (cmd_hit);
	COV_SOFT_RESET: cover property (soft_hit);

endmodule // adc_serial_readout_control
`default_nettype wire

/* File: core/serial_out_shifter.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Parallel-load shifter, most significant bit first.
// ----------------------------------------------------------------------------
module serial_out_shifter #(
	parameter int WIDTH = 32
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst,
	// Load and shift controls.
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_data,
	input  wire logic             shift,
	// Serial bit, straight from the flip-flop.
	output logic                  msb
);
	logic [WIDTH-1:0] sr;
	logic [WIDTH-1:0] next_sr;

	// A load wins over a shift so a new result is never half-shifted.
	always_comb begin
		next_sr = sr;
		if (load) begin
			next_sr = load_data;
		end else if (shift) begin
			next_sr = {sr[WIDTH-2:0], 1'b0};
		end
	end

	// Register the shifter.
	always_ff @(posedge clk) begin
		if (rst) begin
			sr <= '0;
		end else begin
			sr <= next_sr;
		end
	end

	assign msb = sr[WIDTH-1];

endmodule // serial_out_shifter
`default_nettype wire

/* File: test/spi_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----
// Host master model, mode 3, serial clock idle high.
// ----
module spi_host_model (
	// Clock.
	input  wire logic clk,
	// Serial pins.
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	logic last;
	logic line;

	// A released output reads as the inverse of its last driven level.
	assign line = sdo_oe ? sdo : ~last;

	// Track the last driven level of the data output.
	always @(posedge clk) begin
		if (sdo_oe)
			last <= sdo;
	end

	// Idle levels from time zero.
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi  = 1'b1;
		last = 1'b0;
	end

	// Select pin, moved just after a falling clock edge.
	task automatic set_cs(input logic v);
		@(negedge clk) cs_n = v;
	endtask

	// Clock n bits out MSB first; each level lasts two clocks.
	// The result is sampled on each rise and the task ends on the last rise.
	task automatic xfer(input int n, input logic [63:0] wd,
		output logic [63:0] rd);
		rd = 64'h0;
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge clk);
			@(negedge clk);
			sclk = 1'b0;
			sdi  = wd[i];
			@(negedge clk);
			@(negedge clk);
			sclk = 1'b1;
			rd   = {rd[62:0], line};
		end
	endtask
endmodule // spi_host_model
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ----
// Self-checking bench for the serial result readout.
// ----
module tb;
	import adc_readout_pkg::*;
	logic        clk, rst, sclk, cs_n, sdi, sdo, sdo_oe, rdy_n, cfg_wr;
	logic        select_pin_function_en, fifo_en, conv_valid, conv_imminent;
	logic        read_abandoned, cont_exit, soft_reset;
	cfg_t        cfg_wdata, cfg_rdata;
	conv_t       conv;
	logic [63:0] rd;
	int          fail_count, compares;

	adc_serial_readout_control dut (.clk(clk), .rst(rst), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .rdy_n(rdy_n),
		.cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.select_pin_function_en(select_pin_function_en), .fifo_en(fifo_en),
		.conv_valid(conv_valid), .conv(conv), .conv_imminent(conv_imminent),
		.read_abandoned(read_abandoned), .cont_exit(cont_exit),
		.soft_reset(soft_reset));
	spi_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe));

	// 20 MHz clock.
	initial clk = 1'b0;
	always #25 clk = ~clk;

	// Value comparison; case equality so unknowns never match.
	task automatic check(input logic [63:0] got, exp, input string msg);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic end_sim();
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Option write; the extra edge lets the read-back settle.
	task automatic write_cfg(input cfg_t v);
		@(negedge clk) cfg_wr = 1'b1;
		cfg_wdata = v;
		@(negedge clk) cfg_wr = 1'b0;
		@(negedge clk);
	endtask

	// Level inputs from the rest of the device, all moved at one falling
	// edge so the select mode, FIFO and warning lines can never skew.
	task automatic set_ctl(input logic sel, input logic fifo,
		input logic imm);
		@(negedge clk);
		select_pin_function_en = sel;
		fifo_en                = fifo;
		conv_imminent          = imm;
	endtask

	task automatic load_conv(input conv_t v);
		@(negedge clk) conv_valid = 1'b1;
		conv = v;
		@(negedge clk) conv_valid = 0;
		@(negedge clk);
	endtask

	// Bounded look for a pulse or level; sel picks the output.
	task automatic wait_sig(input int sel, output logic seen);
		logic s;
		seen = 1'b0;
		repeat (8) begin
			@(negedge clk);
			s = (sel == 0) ? read_abandoned : (sel == 1) ? cont_exit :
				(sel == 2) ? soft_reset : rdy_n;
			if (s === 1'b1)
				seen = 1'b1;
		end
	endtask

	// Three-wire continuous frame, ignored early clocks, then release.
	task automatic t_frame(input logic dly, input logic st);
		int          n;
		int          cnt;
		conv_t       v;
		logic [63:0] exp;
		n   = st ? 32 : 24;
		v   = conv_t'({24'hc35a96, 6'h0, dly, st});
		exp = st ? 64'(v) : 64'(v.data);
		write_cfg(cfg_t'({dly, 1'b1, st}));
		host.xfer(8, 64'h0, rd);
		check(64'(rdy_n), 64'h1, "early clocks");
		load_conv(v);
		check(64'(rdy_n), 64'h0, "ready low");
		host.xfer(n, 64'h0, rd);
		check(rd & ((64'h1 << n) - 64'h1), exp, "frame data");
		cnt = 0;
		repeat (4) begin
			@(negedge clk);
			if (sdo_oe === 1'b1)
				cnt++;
		end
		check(64'(cnt), 64'(dly ? REL_LONG_CYC : REL_SHORT_CYC),
			"release");
		check(64'(rdy_n), 64'h1, "ready back");
	endtask

	// Four-wire select, abandon, FIFO block, exit and soft reset.
	task automatic t_four();
		logic seen;
		set_ctl(1'b1, 1'b0, 1'b0);
		write_cfg(cfg_t'(3'h2));
		load_conv(conv_t'(32'h12345678));
		check(64'({rdy_n, sdo_oe}), 64'h0, "select high");
		host.set_cs(1'b0);
		host.xfer(3, 64'h0, rd);
		host.set_cs(1'b1);
		wait_sig(3, seen);
		check(64'({seen, sdo_oe}), 64'h2, "select rise");
		load_conv(conv_t'(32'h9abcdef0));
		host.set_cs(1'b0);
		host.xfer(5, 64'h0, rd);
		set_ctl(1'b1, 1'b0, 1'b1);
		set_ctl(1'b1, 1'b0, 1'b0);
		check(64'({read_abandoned, rdy_n, sdo_oe}), 64'h6, "abandon");
		@(negedge clk);
		// The host learns of the spent read from the abandon pulse, which
		// stands in here for the check word it would otherwise verify.
		check(64'(read_abandoned), 64'h0, "abandon width");
		host.set_cs(1'b1);
		load_conv(conv_t'(32'h0f0f0f0f));
		check(64'(rdy_n), 64'h0, "before fifo");
		set_ctl(1'b1, 1'b1, 1'b0);
		@(negedge clk);
		check(64'(rdy_n), 64'h1, "fifo on");
		load_conv(conv_t'(32'h0f0f0f0f));
		check(64'(rdy_n), 64'h1, "fifo load");
		set_ctl(1'b1, 1'b0, 1'b0);
		host.set_cs(1'b0);
		host.xfer(8, 64'(READ_DATA_CMD), rd);
		wait_sig(1, seen);
		check(64'({seen, cfg_rdata}), 64'h8, "exit");
		load_conv(conv_t'(32'h55aa55aa));
		check(64'(rdy_n), 64'h1, "mode left");
		write_cfg(cfg_t'(3'h7));
		host.xfer(64, {64{1'b1}}, rd);
		wait_sig(2, seen);
		check(64'({seen, cfg_rdata}), 64'h8, "soft reset");
		host.set_cs(1'b1);
	endtask

	// Main sequence.
	initial begin
		fail_count = 0;
		compares = 0;
		rst = 1'b1;
		cfg_wr = 1'b0;
		cfg_wdata = cfg_t'(3'h0);
		select_pin_function_en = 1'b0;
		fifo_en = 1'b0;
		conv_valid = 1'b0;
		conv = conv_t'(32'h0);
		conv_imminent = 1'b0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check(64'({cfg_rdata, rdy_n, sdo_oe}), 64'h2, "reset");
		write_cfg(cfg_t'(3'h5));
		check(64'(cfg_rdata), 64'h5, "option read");
		host.set_cs(1'b0);
		for (int i = 0; i < 4; i++) begin
			t_frame(i[1], i[0]);
		end
		host.set_cs(1'b1);
		t_four();
		end_sim();
	end

	// Watchdog, well beyond the roughly one thousand cycles the run needs.
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_sim();
	end
endmodule // tb
`default_nettype wire
